// ==== bench/can_irq_enable_and_tx_abort_test.sv ====
// self-checking bench for the irq enable / tx abort block
`timescale 1ns/1ps
`include "cieta_defs.svh"
module can_irq_enable_and_tx_abort_test;
  import cieta_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, er;
  logic wake = 1'b0, ovr = 1'b0, rxf = 1'b0, pready, pslverr, ack, ireq, lsn;
  logic [1:0] rs = 2'h0, ts = 2'h0;
  logic [11:0] pa = 12'h0;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [2:0] fail = 3'h0, st, sched, grant, blk;
  cieta_txev_t done;
  cieta_irq_t irq;
  int error_cnt = 0, cmp_count = 0, seed = 32, v;
  int m_rier = 0, m_tflg = 7, m_tier = 0, m_tarq = 0, m_taak = 0, m_ctrl = 1;
  cieta_top cieta_top_i (.i_clk, .i_nrst, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(pslverr),
    .i_init_mode_acknowledge(ack), .i_wakeup_flag(wake), .i_overrun_flag(ovr),
    .i_rx_full_flag(rxf), .i_rx_state_actual(rs), .i_tx_state_actual(ts), .i_tx_started(st),
    .i_tx_failed(fail), .i_tx_done(done), .o_tx_scheduled(sched), .o_abort_grant(grant),
    .o_buffer_access_blocked(blk), .o_init_mode_request(ireq), .o_listen_only(lsn), .o_irq(irq));
  cieta_sched cieta_sched_i (.i_clk, .i_nrst, .i_go(go), .i_init_mode_request(ireq),
    .i_tx_scheduled(sched), .o_ack(ack), .o_started(st), .o_done(done));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_clk) pen <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prd;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input int d);
    int clr;
    clr = m_tflg & d & 7;
    apb(1'b1, a, d);
    if (a == `CIETA_OFF_CTRL) m_ctrl = d & 3;
    if (m_ctrl[0]) {m_rier, m_tier, m_tarq, m_taak, m_tflg} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h7};
    else if (a == `CIETA_OFF_RIER) m_rier = d & 'hff;
    else if (a == `CIETA_OFF_TIER) m_tier = d & 7;
    else if (a == `CIETA_OFF_TARQ) m_tarq |= d & ~m_tflg & 7;
    else if (a == `CIETA_OFF_TFLG && !m_ctrl[1]) begin
      m_tflg &= ~clr;
      m_taak &= ~clr;
    end
  endtask : wr
  task automatic rdall;
    int e[7];
    e = '{m_rier, m_tflg, m_tier, m_tarq, m_taak, 0, m_ctrl};
    for (int i = 0; i < 7; i++) begin
      if (i != 5) apb(1'b0, 12'(4 * i), 32'h0);
      if (i != 5) chk("reg", rd, e[i]);
    end
    chk("irq_tx", irq.tx, m_tflg & m_tier);
    chk("blocked", blk, ~m_tflg & 7);
  endtask : rdall
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    wr(`CIETA_OFF_RIER, 'hff);
    wr(`CIETA_OFF_TFLG, 7);
    rdall();
    $display("test init done");
    wr(`CIETA_OFF_CTRL, 0);
    // wake enable set for stop recovery
    wr(`CIETA_OFF_RIER, 'h83);
    {wake, ovr, rxf} <= 3'h7;
    repeat (2) @(posedge i_clk);
    chk("irq_on", {irq.wakeup, irq.error, irq.rx}, 3'h7);
    wr(`CIETA_OFF_RIER, 0);
    @(posedge i_clk);
    chk("irq_off", {irq.wakeup, irq.error, irq.rx}, 3'h0);
    {wake, ovr, rxf} <= 3'h0;
    // status change flag sets once, then holds the state fields
    wr(`CIETA_OFF_RIER, 'h7c);
    ts <= 2'h1;
    repeat (3) @(posedge i_clk);
    ts <= 2'h2;
    repeat (3) @(posedge i_clk);
    chk("err_irq", irq.error, 1);
    apb(1'b0, `CIETA_OFF_STAT, 32'h0);
    chk("stat_held", rd, 'h41);
    wr(`CIETA_OFF_STAT, 'h40);
    repeat (3) @(posedge i_clk);
    apb(1'b0, `CIETA_OFF_STAT, 32'h0);
    chk("stat_new", rd, 'h42);
    $display("test enables done");
    {rs, ts} <= 4'($random(seed));
    v = ($random(seed) & 7) | 2;
    wr(`CIETA_OFF_TIER, v);
    wr(`CIETA_OFF_TFLG, 'h2);
    rdall();
    wr(`CIETA_OFF_TARQ, 'h7);
    m_tflg |= 2;
    m_taak |= 2;
    m_tarq = 0;
    @(posedge i_clk);
    rdall();
    $display("test abort done");
    wr(`CIETA_OFF_TFLG, 'h2);
    go <= 1'b1;
    for (int n = 0; n < 20 && blk !== 3'h0; n++) @(posedge i_clk);
    m_tflg |= 2;
    wr(`CIETA_OFF_TAAK, 7);
    rdall();
    $display("test send done");
    wr(`CIETA_OFF_CTRL, 2);
    wr(`CIETA_OFF_TFLG, 7);
    rdall();
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", er, 1);
    chk("unmapped", rd, 0);
    $display("test listen done");
    wr(`CIETA_OFF_CTRL, 1);
    repeat (3) @(posedge i_clk);
    rdall();
    $display("test reinit done");
    wrap_up();
  end
endmodule : can_irq_enable_and_tx_abort_test

// ==== bench/cieta_sched.sv ====
// transmit scheduler and init handshake model of the controller side
`timescale 1ns/1ps
module cieta_sched
  import cieta_pkg::*;
(
  // clock, reset and pacing
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_go,
  // from the block
  input wire logic i_init_mode_request,
  input wire logic [2:0] i_tx_scheduled,
  // to the block
  output logic o_ack,
  output logic [2:0] o_started,
  output cieta_txev_t o_done
);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack <= 1'b0;
      o_started <= 3'h0;
      o_done <= '0;
    end else begin
      o_ack <= i_init_mode_request;
      // held off while go is low, so aborts land before start
      o_started <= i_tx_scheduled & (o_started | {3{i_go}});
      o_done.sent_ok <= i_tx_scheduled & o_started & ~o_done.sent_ok;
      o_done.abort_granted <= 3'h0;
    end
  end
endmodule : cieta_sched

// ==== bench/cieta_sva.sv ====
// assertion checker for the irq enable / tx abort block
`timescale 1ns/1ps
module cieta_sva
  import cieta_pkg::*;
(
  // watched ports
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_init_mode_acknowledge,
  input wire logic i_wakeup_flag,
  input wire logic i_rx_full_flag,
  input wire logic [2:0] i_tx_started,
  input wire logic [2:0] i_tx_failed,
  input wire cieta_txev_t i_tx_done,
  input wire logic [2:0] o_tx_scheduled,
  input wire logic [2:0] o_abort_grant,
  input wire logic [2:0] o_buffer_access_blocked,
  input wire logic o_init_mode_request,
  input wire logic o_listen_only,
  input wire cieta_irq_t o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire logic init_on = o_init_mode_request && i_init_mode_acknowledge;
  AST_INIT_HOLD: assert property (init_on [*2] |-> o_buffer_access_blocked == 3'h0 &&
    !o_irq.wakeup && !o_irq.rx && o_irq.tx == 3'h0) else $error("init mode did not hold reset");
  AST_WAKE_GATE: assert property (!i_wakeup_flag |-> !o_irq.wakeup)
    else $error("wakeup request without event");
  AST_RXF_GATE: assert property (!i_rx_full_flag |-> !o_irq.rx)
    else $error("receive request without full flag");
  AST_TX_IRQ: assert property ((o_irq.tx & o_buffer_access_blocked) == 3'h0)
    else $error("transmit request on a full buffer");
  AST_SCHED: assert property (o_tx_scheduled == (o_listen_only ? 3'h0 : o_buffer_access_blocked))
    else $error("scheduled set does not follow flags");
  AST_GRANT_COND: assert property ((o_abort_grant &
    ~(o_buffer_access_blocked & (~i_tx_started | i_tx_failed))) == 3'h0)
    else $error("abort granted while sending");
  AST_GRANT_EMPTY: assert property (o_abort_grant != 3'h0 |=>
    (o_buffer_access_blocked & $past(o_abort_grant)) == 3'h0) else $error("abort left buffer full");
  AST_SENT_EMPTY: assert property (i_tx_done.sent_ok != 3'h0 |=>
    (o_buffer_access_blocked & $past(i_tx_done.sent_ok)) == 3'h0) else $error("sent buffer not empty");
  cover property (o_abort_grant != 3'h0);
  cover property (i_tx_done.sent_ok != 3'h0);
  cover property (init_on ##1 !init_on);
endmodule : cieta_sva
bind cieta_top cieta_sva cieta_sva_i (.i_clk, .i_nrst, .i_init_mode_acknowledge, .i_wakeup_flag,
  .i_rx_full_flag, .i_tx_started, .i_tx_failed, .i_tx_done, .o_tx_scheduled, .o_abort_grant,
  .o_buffer_access_blocked, .o_init_mode_request, .o_listen_only, .o_irq);

// ==== rtl/cieta_defs.svh ====
// register offsets, field positions and reset values of the irq enable / tx abort block
`ifndef CIETA_DEFS_SVH
`define CIETA_DEFS_SVH
`define CIETA_OFF_RIER 12'h000
`define CIETA_OFF_TFLG 12'h004
`define CIETA_OFF_TIER 12'h008
`define CIETA_OFF_TARQ 12'h00c
`define CIETA_OFF_TAAK 12'h010
`define CIETA_OFF_STAT 12'h014
`define CIETA_OFF_CTRL 12'h018
`define CIETA_RIER_WAKEUP_IRQ_ENABLE 7
`define CIETA_RIER_STATUS_CHANGE_IRQ_ENABLE 6
`define CIETA_RIER_RSENS_HI 5
`define CIETA_RIER_RSENS_LO 4
`define CIETA_RIER_TSENS_HI 3
`define CIETA_RIER_TSENS_LO 2
`define CIETA_RIER_OVERRUN_IRQ_ENABLE 1
`define CIETA_RIER_RX_FULL_IRQ_ENABLE 0
`define CIETA_STAT_CSC 6
`define CIETA_CTRL_INIT_MODE_REQUEST 0
`define CIETA_CTRL_LISTEN 1
`define CIETA_RIER_RST 8'h00
`define CIETA_TFLG_RST 3'h7
`define CIETA_ZERO3 3'h0
`define CIETA_NBUF 3
`endif

// ==== rtl/cieta_pkg.sv ====
// types of the irq enable / tx abort block
package cieta_pkg;
  typedef enum logic [1:0] {
    cieta_st_ok = 2'h0,
    cieta_st_warn = 2'h1,
    cieta_st_err = 2'h2,
    cieta_st_off = 2'h3
  } cieta_estate_t;
  typedef struct packed {
    logic [2:0] sent_ok;
    logic [2:0] abort_granted;
  } cieta_txev_t;
  typedef struct packed {
    logic wakeup;
    logic error;
    logic rx;
    logic [2:0] tx;
  } cieta_irq_t;
endpackage : cieta_pkg

// ==== rtl/cieta_top.sv ====
// interrupt enables, status change, tx empty flags and abort handshake of a can controller
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cieta_defs.svh"
module cieta_top
  import cieta_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // controller status
  input wire logic i_init_mode_acknowledge,
  input wire logic i_wakeup_flag,
  input wire logic i_overrun_flag,
  input wire logic i_rx_full_flag,
  input wire logic [1:0] i_rx_state_actual,
  input wire logic [1:0] i_tx_state_actual,
  // transmit scheduler
  input wire logic [2:0] i_tx_started,
  input wire logic [2:0] i_tx_failed,
  input wire cieta_txev_t i_tx_done,
  output logic [2:0] o_tx_scheduled,
  output logic [2:0] o_abort_grant,
  output logic [2:0] o_buffer_access_blocked,
  // mode and requests
  output logic o_init_mode_request,
  output logic o_listen_only,
  output cieta_irq_t o_irq
);
  logic [7:0] receive_interrupt_enable;
  logic [2:0] transmit_buffer_empty_flags;
  logic [2:0] transmit_interrupt_enable;
  logic [2:0] transmit_abort_request;
  logic [2:0] transmit_abort_acknowledge;
  logic [1:0] rx_state_sensitivity;
  logic [1:0] tx_state_sensitivity;
  logic [1:0] rx_error_state;
  logic [1:0] tx_error_state;
  logic status_change_flag;
  logic init_mode_request;
  logic listen_only;

  wire in_init = init_mode_request & i_init_mode_acknowledge;
  wire acc = i_psel & i_penable;
  wire wr = acc & i_pwrite & ~in_init;
  wire sel_rier = (i_paddr == `CIETA_OFF_RIER);
  wire sel_tflg = (i_paddr == `CIETA_OFF_TFLG);
  wire sel_tier = (i_paddr == `CIETA_OFF_TIER);
  wire sel_tarq = (i_paddr == `CIETA_OFF_TARQ);
  wire sel_taak = (i_paddr == `CIETA_OFF_TAAK);
  wire sel_stat = (i_paddr == `CIETA_OFF_STAT);
  wire sel_ctrl = (i_paddr == `CIETA_OFF_CTRL);
  wire mapped = sel_rier | sel_tflg | sel_tier | sel_tarq | sel_taak | sel_stat | sel_ctrl;

  // host clear of empty flags, dropped in listen-only mode
  wire [2:0] host_clr = (wr && sel_tflg && !listen_only) ? i_pwdata[2:0] : `CIETA_ZERO3;
  // host may only set abort requests, and only on buffers whose empty flag is clear, listen-only or not
  wire [2:0] host_abort = (wr && sel_tarq) ? i_pwdata[2:0] : `CIETA_ZERO3;
  // grant only if not started, or attempt failed
  wire [2:0] grant = transmit_abort_request & ~transmit_buffer_empty_flags
                     & (~i_tx_started | i_tx_failed);
  // sent ok or abort granted sets empty
  wire [2:0] set_empty = (i_tx_done.sent_ok | grant) & ~transmit_buffer_empty_flags;

  function automatic logic sens_hit(input logic [1:0] s, input logic [1:0] o,
                                    input logic [1:0] n);
    logic off_edge;
    logic err_edge;
    off_edge = (o == cieta_st_off) != (n == cieta_st_off);
    err_edge = off_edge | ((o == cieta_st_err) != (n == cieta_st_err));
    case (s)
      2'h3: sens_hit = (o != n);
      2'h2: sens_hit = err_edge;
      2'h1: sens_hit = off_edge;
      default: sens_hit = 1'b0;
    endcase
  endfunction : sens_hit

  // leaving tx bus-off forces receiver ok
  wire tx_leave_off = (tx_error_state == cieta_st_off) && (i_tx_state_actual != cieta_st_off);
  wire [1:0] rx_target = tx_leave_off ? cieta_st_ok :
                         ((i_tx_state_actual == cieta_st_off) ? cieta_st_off : i_rx_state_actual);
  wire csc_event = sens_hit(rx_state_sensitivity, rx_error_state, rx_target)
                 | sens_hit(tx_state_sensitivity, tx_error_state, i_tx_state_actual);
  wire csc_clr = wr && sel_stat && i_pwdata[`CIETA_STAT_CSC];

  // state fields and status change flag, untouched by init mode
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_error_state <= cieta_st_ok;
      tx_error_state <= cieta_st_ok;
      status_change_flag <= 1'b0;
      rx_state_sensitivity <= 2'h0;
      tx_state_sensitivity <= 2'h0;
    end else begin
      if (!status_change_flag) begin
        rx_error_state <= rx_target;
        tx_error_state <= i_tx_state_actual;
      end
      // set wins over clear
      if (!status_change_flag && csc_event) begin
        status_change_flag <= 1'b1;
      end else if (csc_clr) begin
        status_change_flag <= 1'b0;
      end
      // sensitivity written outside init only, never reset by it
      if (wr && sel_rier) begin
        rx_state_sensitivity <= i_pwdata[`CIETA_RIER_RSENS_HI:`CIETA_RIER_RSENS_LO];
        tx_state_sensitivity <= i_pwdata[`CIETA_RIER_TSENS_HI:`CIETA_RIER_TSENS_LO];
      end
    end
  end

  // control register: init request and listen-only always writable
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      init_mode_request <= 1'b1;
      listen_only <= 1'b0;
    end else if (acc && i_pwrite && sel_ctrl) begin
      init_mode_request <= i_pwdata[`CIETA_CTRL_INIT_MODE_REQUEST];
      listen_only <= i_pwdata[`CIETA_CTRL_LISTEN];
    end
  end

  // enable register held at reset in init mode
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      receive_interrupt_enable <= `CIETA_RIER_RST;
      transmit_interrupt_enable <= `CIETA_ZERO3;
    end else if (in_init) begin
      receive_interrupt_enable <= `CIETA_RIER_RST;
      transmit_interrupt_enable <= `CIETA_ZERO3;
    end else begin
      if (wr && sel_rier) begin
        receive_interrupt_enable <= i_pwdata[7:0];
      end
      if (wr && sel_tier) begin
        transmit_interrupt_enable <= i_pwdata[2:0];
      end
    end
  end

  // per-buffer flag, request and acknowledge
  genvar b;
  generate
    for (b = 0; b < `CIETA_NBUF; b = b + 1) begin : g_buf
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          transmit_buffer_empty_flags[b] <= 1'b1;
          transmit_abort_request[b] <= 1'b0;
          transmit_abort_acknowledge[b] <= 1'b0;
        end else if (in_init) begin
          transmit_buffer_empty_flags[b] <= 1'b1;
          transmit_abort_request[b] <= 1'b0;
          transmit_abort_acknowledge[b] <= 1'b0;
        end else if (set_empty[b]) begin
          // set empty, drop request, ack only on abort
          transmit_buffer_empty_flags[b] <= 1'b1;
          transmit_abort_request[b] <= 1'b0;
          transmit_abort_acknowledge[b] <= grant[b];
        end else if (host_clr[b] && transmit_buffer_empty_flags[b]) begin
          transmit_buffer_empty_flags[b] <= 1'b0;
          transmit_abort_acknowledge[b] <= 1'b0;
        end else if (host_abort[b] && !transmit_buffer_empty_flags[b]) begin
          transmit_abort_request[b] <= 1'b1;
        end
      end
    end
  endgenerate

  assign o_tx_scheduled = listen_only ? `CIETA_ZERO3 : ~transmit_buffer_empty_flags;
  assign o_buffer_access_blocked = ~transmit_buffer_empty_flags;
  assign o_abort_grant = grant;
  assign o_init_mode_request = init_mode_request;
  assign o_listen_only = listen_only;

  assign o_irq.wakeup = i_wakeup_flag & receive_interrupt_enable[`CIETA_RIER_WAKEUP_IRQ_ENABLE];
  assign o_irq.error = (status_change_flag & receive_interrupt_enable[`CIETA_RIER_STATUS_CHANGE_IRQ_ENABLE])
                     | (i_overrun_flag & receive_interrupt_enable[`CIETA_RIER_OVERRUN_IRQ_ENABLE]);
  assign o_irq.rx = i_rx_full_flag & receive_interrupt_enable[`CIETA_RIER_RX_FULL_IRQ_ENABLE];
  assign o_irq.tx = transmit_buffer_empty_flags & transmit_interrupt_enable;

  // abort ack has no write path
  wire [31:0] rd_mux =
    sel_rier ? {24'h0, receive_interrupt_enable} :
    sel_tflg ? {29'h0, transmit_buffer_empty_flags} :
    sel_tier ? {29'h0, transmit_interrupt_enable} :
    sel_tarq ? {29'h0, transmit_abort_request} :
    sel_taak ? {29'h0, transmit_abort_acknowledge} :
    sel_stat ? {25'h0, status_change_flag, 2'h0, rx_error_state, tx_error_state} :
    sel_ctrl ? {30'h0, listen_only, init_mode_request} : 32'h0;

  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~mapped;
  assign o_prdata = (acc && !i_pwrite) ? rd_mux : 32'h0;
endmodule : cieta_top
